// *** src/fldps_map.svh ***
`ifndef FLDPS_MAP_SVH
`define FLDPS_MAP_SVH

// register word indices; byte address is four times the index
`define FLDPS_CTRL_IDX    10'h00b
`define FLDPS_STAT_IDX    10'h010
`define FLDPS_MASK_IDX    10'h011

// control word field positions
`define FLDPS_DSC_BIT     10
`define FLDPS_POL_BIT     6
`define FLDPS_SWAP_BIT    5
`define FLDPS_RXERR_BIT   3
`define FLDPS_MLT3_BIT    2
`define FLDPS_SNR_BIT     1
`define FLDPS_ENERGY_BIT  0

// reset values and writable bits (bit 9 is read-only zero)
`define FLDPS_CTRL_RST    16'h0000
`define FLDPS_CTRL_WMASK  16'hfdff
`define FLDPS_STAT_RST    16'h0000
`define FLDPS_MASK_RST    16'h0000

// counting monitors: events per window that drop the link
`define FLDPS_RXERR_LIMIT 32
`define FLDPS_MLT3_LIMIT  20
`define FLDPS_SNR_LIMIT   20

// window timing
`define FLDPS_WINDOW_NS   10000
`define FLDPS_CLK_NS      10
`define FLDPS_WINDOW_CYC  (`FLDPS_WINDOW_NS / `FLDPS_CLK_NS)

`endif

// *** src/fldps_pkg.sv ***
package fldps_pkg;

  typedef logic [15:0] fldps_word_t;

  typedef enum logic [1:0] {
    FLDPS_ST_SETTLE = 2'b00,
    FLDPS_ST_LOAD   = 2'b01,
    FLDPS_ST_RUN    = 2'b10
  } fldps_strap_st_t;

endpackage

// *** src/fldps_win_counter.sv ***
`timescale 1ns/100ps
`default_nettype none

module fldps_win_counter #(
  parameter int WIDTH  = 6,
  parameter int THRESH = 32
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic enable,
  input  wire logic win_start,
  input  wire logic event_in,
  // result
  output logic      hit_r
);

  localparam logic [WIDTH-1:0] LIMIT = WIDTH'(THRESH);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (!enable) begin
      count_nxt = '0;
    end else if (win_start) begin
      // an event on the window edge belongs to the new window
      count_nxt = event_in ? WIDTH'(1) : '0;
    end else if (event_in && count_r != LIMIT) begin
      count_nxt = count_r + WIDTH'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // one pulse when the limit is first reached in a window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= (count_nxt == LIMIT) && (count_r != LIMIT);
    end
  end

endmodule

`default_nettype wire

// *** src/fldps_top.sv ***
// Operation
// (R1) descrambler lock loss drops link when enabled
// (R2) drop is OR of five enabled monitors
// (R3) 32 receive errors per 10us drop
// (R4) 20 line-code violations per 10us drop
// (R5) 20 low-SNR crossings per 10us drop
// (R6) energy loss drops link when enabled
// (R7) energy mode reset from strap, MII enhanced
// (R8) polarity bit inverts both cable pairs
// (R9) swap bit exchanges transmit and receive pairs
// (R10) software sets both bits for mirroring
// (R11) monitor counts clear every new window
`include "fldps_map.svh"
`timescale 1ns/100ps
`default_nettype none

module fldps_top
  import fldps_pkg::*;
(
  // ahb-lite clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // monitors from receive logic, same clock
  input  wire logic        descr_locked,
  input  wire logic        mac_rx_error,
  input  wire logic        line_code_violation,
  input  wire logic        low_snr_crossing,
  input  wire logic        energy_present,
  // straps from pins
  input  wire logic        common_pin_mode,
  input  wire logic        rmii_select,
  input  wire logic        strap_energy_drop,
  // link control
  output logic             link_drop,
  output logic             tx_pair_invert,
  output logic             rx_pair_invert,
  output logic             pair_role_exchange,
  // interrupt
  output logic             irq
);

  localparam int WIN_CYC = `FLDPS_WINDOW_CYC;
  localparam logic [9:0] WIN_LAST = 10'(WIN_CYC - 1);

  // bus state
  logic        hreadyout_r;
  logic [31:0] hrdata_r;
  logic        wr_pend_r;
  logic [9:0]  wr_idx_r;
  logic        rd_req;
  logic        wr_req;
  logic [9:0]  req_idx;
  logic        wr_ctrl;
  logic        wr_mask;
  logic        rd_stat;

  // registers
  fldps_word_t ctrl_r;
  fldps_word_t stat_r;
  fldps_word_t stat_nxt;
  fldps_word_t mask_r;
  fldps_word_t ev_word;
  fldps_word_t rd_word;

  // strap capture
  logic [2:0]      strap_s1_r;
  logic [2:0]      strap_s2_r;
  logic [2:0]      strap_s3_r;
  fldps_strap_st_t strap_st_r;
  fldps_strap_st_t strap_st_nxt;
  logic [1:0]      strap_fill_r;

  // monitors
  logic        locked_q_r;
  logic        energy_q_r;
  logic        dsc_loss;
  logic        energy_loss;
  logic [9:0]  win_cnt_r;
  logic        win_start;
  logic [2:0]  cnt_en;
  logic [2:0]  cnt_ev;
  logic [2:0]  cnt_hit;
  logic [4:0]  drop_ev;

  // outputs
  logic        link_drop_r;
  logic        tx_inv_r;
  logic        rx_inv_r;
  logic        swap_r;
  logic        irq_r;

  // ---------------- bus decode ----------------

  assign req_idx = haddr[11:2];
  assign rd_req  = hsel && hready && htrans[1] && !hwrite;
  assign wr_req  = hsel && hready && htrans[1] && hwrite;
  assign rd_stat = rd_req && (req_idx == `FLDPS_STAT_IDX);
  assign wr_ctrl = wr_pend_r && (wr_idx_r == `FLDPS_CTRL_IDX);
  assign wr_mask = wr_pend_r && (wr_idx_r == `FLDPS_MASK_IDX);

  // ready is low in reset; after that the slave never stalls and always answers okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
    end
  end

  // writes land in the data phase, one cycle after the address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 10'h000;
    end else begin
      wr_pend_r <= wr_req;
      wr_idx_r  <= req_idx;
    end
  end

  // read data is formed at the address phase so it stands in the data
  // phase; a write still pending to the same word is forwarded
  always_comb begin
    rd_word = 16'h0000;
    unique case (req_idx)
      `FLDPS_CTRL_IDX: begin
        rd_word = wr_ctrl ? (hwdata[15:0] & `FLDPS_CTRL_WMASK) : ctrl_r;
      end
      `FLDPS_STAT_IDX: begin
        rd_word = stat_r | ev_word;
      end
      `FLDPS_MASK_IDX: begin
        rd_word = wr_mask ? hwdata[15:0] : mask_r;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_req) begin
      hrdata_r <= {16'h0000, rd_word};
    end
  end

  // ---------------- strap capture ----------------

  // pins pass three flip-flops; settled once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
      strap_s3_r <= 3'h0;
      strap_fill_r <= 2'h0;
    end else begin
      strap_s1_r <= {common_pin_mode, rmii_select, strap_energy_drop};
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
      if (strap_fill_r != 2'h3) begin
        strap_fill_r <= strap_fill_r + 2'h1;
      end
    end
  end

  always_comb begin
    strap_st_nxt = strap_st_r;
    unique case (strap_st_r)
      FLDPS_ST_SETTLE: begin
        // reset zeros agree too, so wait until real pin values fill stage 3
        if (strap_fill_r == 2'h3 && strap_s2_r == strap_s3_r) begin
          strap_st_nxt = FLDPS_ST_LOAD;
        end
      end
      FLDPS_ST_LOAD: begin
        strap_st_nxt = FLDPS_ST_RUN;
      end
      FLDPS_ST_RUN: begin
        strap_st_nxt = FLDPS_ST_RUN;
      end
      default: begin
        strap_st_nxt = FLDPS_ST_SETTLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_st_r <= FLDPS_ST_SETTLE;
    end else begin
      strap_st_r <= strap_st_nxt;
    end
  end

  // ---------------- control register ----------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `FLDPS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= hwdata[15:0] & `FLDPS_CTRL_WMASK;
    end else if (strap_st_r == FLDPS_ST_LOAD) begin
      // (R7) strap default bit
      // only enhanced pin mode with mii takes the strap; others keep 0
      ctrl_r[`FLDPS_ENERGY_BIT] <= !strap_s3_r[2] && !strap_s3_r[1]
                                   && strap_s3_r[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= `FLDPS_MASK_RST;
    end else if (wr_mask) begin
      mask_r <= hwdata[15:0];
    end
  end

  // ---------------- monitors ----------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      locked_q_r <= 1'b0;
      energy_q_r <= 1'b0;
    end else begin
      locked_q_r <= descr_locked;
      energy_q_r <= energy_present;
    end
  end

  // (R1) lock loss edge
  assign dsc_loss    = ctrl_r[`FLDPS_DSC_BIT] && locked_q_r && !descr_locked;
  // (R6) energy loss edge
  assign energy_loss = ctrl_r[`FLDPS_ENERGY_BIT] && energy_q_r
                       && !energy_present;

  // free-running window shared by all counting monitors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_cnt_r <= 10'h000;
    end else if (win_cnt_r == WIN_LAST) begin
      win_cnt_r <= 10'h000;
    end else begin
      win_cnt_r <= win_cnt_r + 10'h001;
    end
  end

  // (R11) window restart clears
  assign win_start = (win_cnt_r == WIN_LAST);

  assign cnt_en = {ctrl_r[`FLDPS_RXERR_BIT],
                   ctrl_r[`FLDPS_MLT3_BIT],
                   ctrl_r[`FLDPS_SNR_BIT]};
  assign cnt_ev = {mac_rx_error, line_code_violation, low_snr_crossing};

  // (R3) (R4) (R5) windowed counters
  // index 2 receive errors, 1 line-code violations, 0 low snr
  for (genvar g = 0; g < 3; g++) begin : g_mon
    localparam int LIM = (g == 2) ? `FLDPS_RXERR_LIMIT :
                         (g == 1) ? `FLDPS_MLT3_LIMIT : `FLDPS_SNR_LIMIT;
    fldps_win_counter #(
      .WIDTH  ($clog2(LIM + 1)),
      .THRESH (LIM)
    ) u_cnt (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .enable    (cnt_en[g]),
      .win_start (win_start),
      .event_in  (cnt_ev[g]),
      .hit_r     (cnt_hit[g])
    );
  end

  // bit order: 4 descrambler, 3 rx error, 2 mlt3, 1 snr, 0 energy
  assign drop_ev = {dsc_loss, cnt_hit, energy_loss};

  // (R2) or of five monitors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_drop_r <= 1'b0;
    end else begin
      link_drop_r <= |drop_ev;
    end
  end

  // ---------------- line pair control ----------------

  // (R8) (R9) polarity and pair roles
  // mirroring needs both bits from software; each bit acts on its own
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_inv_r <= 1'b0;
      rx_inv_r <= 1'b0;
      swap_r   <= 1'b0;
    end else begin
      tx_inv_r <= ctrl_r[`FLDPS_POL_BIT];
      rx_inv_r <= ctrl_r[`FLDPS_POL_BIT];
      swap_r   <= ctrl_r[`FLDPS_SWAP_BIT];
    end
  end

  // ---------------- interrupt status ----------------

  assign ev_word = {5'h00, drop_ev[4], 6'h00, drop_ev[3:0]};

  // read clears, but an event in the same cycle survives the clear
  always_comb begin
    stat_nxt = rd_stat ? 16'h0000 : stat_r;
    stat_nxt = stat_nxt | ev_word;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= `FLDPS_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  // ---------------- outputs ----------------

  assign hrdata             = hrdata_r;
  assign hreadyout          = hreadyout_r;
  assign hresp              = 1'b0;
  assign link_drop          = link_drop_r;
  assign tx_pair_invert     = tx_inv_r;
  assign rx_pair_invert     = rx_inv_r;
  assign pair_role_exchange = swap_r;
  assign irq                = irq_r;

endmodule

`default_nettype wire

// *** dv/fldps_assertions.sv ***
`include "fldps_map.svh"
`timescale 1ns/100ps
`default_nettype none

module fldps_assertions
  import fldps_pkg::*;
(
  // bus side
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // monitors
  input wire logic        descr_locked,
  input wire logic        mac_rx_error,
  input wire logic        energy_present,
  // link control
  input wire logic        link_drop,
  input wire logic        tx_pair_invert,
  input wire logic        rx_pair_invert,
  input wire logic        pair_role_exchange
);
  logic        wr_p;
  fldps_word_t ctrl_s;
  logic [9:0]  win;
  logic [9:0]  rx_c;
  wire  [4:0]  en = {ctrl_s[10], ctrl_s[3:0]};

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // shadow control word; strap-loaded bit 0 is not tracked, so only
  // written values of it are trusted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_p   <= 1'b0;
      ctrl_s <= `FLDPS_CTRL_RST;
      win    <= 10'h000;
      rx_c   <= 10'h000;
    end else begin
      wr_p <= hsel && hready && htrans[1] && hwrite
              && haddr[11:2] == `FLDPS_CTRL_IDX;
      if (wr_p) begin
        ctrl_s <= hwdata[15:0] & `FLDPS_CTRL_WMASK;
      end
      win  <= (win == 10'h3e7) ? 10'h000 : win + 10'h001;
      rx_c <= ((win == 10'h3e7 || !ctrl_s[3]) ? 10'h000 : rx_c)
              + {9'h000, mac_rx_error & ctrl_s[3]};
    end
  end

  property p_dsc;
    $fell(descr_locked) && ctrl_s[10] |-> ##[1:2] link_drop;
  endproperty
  a_dsc: assert property (p_dsc)
    else $error("lock loss gave no drop");

  property p_off;
    (en == 5'h00) [*3] |-> !link_drop;
  endproperty
  a_off: assert property (p_off)
    else $error("drop with all monitors off");

  property p_rx;
    rx_c == 10'h01f && mac_rx_error && ctrl_s[3] && win != 10'h3e7
      |-> ##[1:2] link_drop;
  endproperty
  a_rx: assert property (p_rx)
    else $error("receive error limit gave no drop");

  property p_energy;
    $fell(energy_present) && ctrl_s[0] |-> ##[1:2] link_drop;
  endproperty
  a_energy: assert property (p_energy)
    else $error("energy loss gave no drop");

  property p_pol;
    tx_pair_invert == $past(ctrl_s[6]);
  endproperty
  a_pol: assert property (p_pol)
    else $error("transmit polarity wrong");

  property p_pol_both;
    rx_pair_invert == tx_pair_invert;
  endproperty
  a_pol_both: assert property (p_pol_both)
    else $error("pair polarities differ");

  property p_swap;
    pair_role_exchange == $past(ctrl_s[5]);
  endproperty
  a_swap: assert property (p_swap)
    else $error("pair roles wrong");

  property p_quiet;
    (en == 5'h08 && rx_c < 10'h01f) [*3] |-> !link_drop;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("drop below window limit");
endmodule

bind fldps_top fldps_assertions fldps_assertions_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .descr_locked(descr_locked), .mac_rx_error(mac_rx_error),
  .energy_present(energy_present), .link_drop(link_drop),
  .tx_pair_invert(tx_pair_invert), .rx_pair_invert(rx_pair_invert),
  .pair_role_exchange(pair_role_exchange)
);
`default_nettype wire

// *** dv/fldps_link_partner.sv ***
`timescale 1ns/100ps
`default_nettype none

module fldps_link_partner (
  // clock
  input  wire logic hclk,
  // monitor lines toward the block
  output logic      descr_locked,
  output logic      mac_rx_error,
  output logic      line_code_violation,
  output logic      low_snr_crossing,
  output logic      energy_present
);
  logic [4:0] ev_r = 5'h00;

  // lock and energy idle high, so only a burst makes them fall
  assign descr_locked        = !ev_r[0];
  assign mac_rx_error        = ev_r[1];
  assign line_code_violation = ev_r[2];
  assign low_snr_crossing    = ev_r[3];
  assign energy_present      = !ev_r[4];

  // kind 5 keeps the line quiet
  task automatic burst(input int kind, input int n);
    repeat (n) @(posedge hclk) ev_r <= 5'(1 << kind);
    @(posedge hclk) ev_r <= 5'h00;
  endtask
endmodule
`default_nettype wire

// *** dv/tb_fast_link_drop_and_pair_swap.sv ***
`include "fldps_map.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_fast_link_drop_and_pair_swap import fldps_pkg::*;;
  typedef struct {
    fldps_word_t c;
    int          k;
    int          n;
    fldps_word_t st;
  } fldps_row_t;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        link_drop, tx_pair_invert, rx_pair_invert;
  logic        pair_role_exchange, descr_locked, mac_rx_error;
  logic        line_code_violation, low_snr_crossing, energy_present;
  logic        common_pin_mode, rmii_select, strap_energy_drop;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  fldps_word_t mask_v;
  int          cyc, drops, base, miscompares, check_count;
  fldps_row_t  rows [13] = '{
    '{16'h0400, 0, 3, 16'h0400},
    '{16'h0000, 0, 3, 16'h0000},
    '{16'h0008, 1, 32, 16'h0008},
    '{16'h0008, 1, 31, 16'h0000},
    '{16'h0004, 2, 20, 16'h0004},
    '{16'h0004, 2, 19, 16'h0000},
    '{16'h0002, 3, 20, 16'h0002},
    '{16'h0002, 3, 19, 16'h0000},
    '{16'h0001, 4, 3, 16'h0001},
    '{16'h040f, 3, 20, 16'h0002},
    '{16'h0060, 5, 0, 16'h0000},
    '{16'h0040, 5, 0, 16'h0000},
    '{16'h0020, 2, 40, 16'h0000}
  };

  fldps_top fldps_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .descr_locked(descr_locked),
    .mac_rx_error(mac_rx_error), .line_code_violation(line_code_violation),
    .low_snr_crossing(low_snr_crossing), .energy_present(energy_present),
    .common_pin_mode(common_pin_mode), .rmii_select(rmii_select),
    .strap_energy_drop(strap_energy_drop), .link_drop(link_drop),
    .tx_pair_invert(tx_pair_invert), .rx_pair_invert(rx_pair_invert),
    .pair_role_exchange(pair_role_exchange), .irq(irq)
  );

  fldps_link_partner fldps_link_partner_i (
    .hclk(hclk), .descr_locked(descr_locked), .mac_rx_error(mac_rx_error),
    .line_code_violation(line_code_violation),
    .low_snr_crossing(low_snr_crossing), .energy_present(energy_present)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // cycle count tracks the free-running window from reset
  always @(posedge hclk or negedge hresetn) begin
    cyc   <= hresetn ? cyc + 1 : 0;
    drops <= drops + int'(link_drop === 1'b1);
  end

  task automatic wait_pos(input int p);
    while (cyc % 1000 != p) @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [9:0] i,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    hwrite <= w;
    htrans <= 2'b10;
    haddr  <= {20'h00000, i, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic run(input fldps_row_t w);
    logic [31:0] q;
    bus(1'b1, `FLDPS_CTRL_IDX, {16'h0000, w.c}, q);
    bus(1'b0, `FLDPS_STAT_IDX, 32'h0, q);
    wait_pos(100);
    base = drops;
    fldps_link_partner_i.burst(w.k, w.n);
    repeat (6) @(posedge hclk);
    chk("drops", 32'(w.st != 16'h0000), drops - base);
    chk("irq", 32'(|(w.st & mask_v)), irq);
    bus(1'b0, `FLDPS_STAT_IDX, 32'h0, q);
    chk("status", {16'h0000, w.st}, q);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("irq_clear", 32'h0, irq);
    chk("pairs", {29'h0, w.c[6], w.c[6], w.c[5]}, {29'h0, tx_pair_invert,
        rx_pair_invert, pair_role_exchange});
    $display("done ctrl %h kind %0d", w.c, w.k);
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge hclk);
    miscompares++;
    conclude();
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {common_pin_mode, rmii_select, strap_energy_drop} = 3'h4;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    mask_v = 16'h040f;
    bus(1'b1, `FLDPS_MASK_IDX, {16'h0000, mask_v}, r);
    foreach (rows[i]) run(rows[i]);
    // straps load bit 0 only for enhanced pins with mii
    for (int s = 0; s < 3; s++) begin
      hresetn <= 1'b0;
      {common_pin_mode, rmii_select, strap_energy_drop} <= {2'(s), 1'b1};
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      bus(1'b0, `FLDPS_CTRL_IDX, 32'h0, r);
      chk("ctrl_reset", {31'h0, s == 0}, r);
      bus(1'b0, `FLDPS_MASK_IDX, 32'h0, r);
      chk("mask_reset", 32'h0, r);
    end
    mask_v = 16'h0000;
    run(rows[0]);
    bus(1'b1, `FLDPS_CTRL_IDX, 32'hffff, r);
    bus(1'b0, `FLDPS_CTRL_IDX, 32'h0, r);
    chk("ctrl_ro", 32'h0000fdff, r);
    bus(1'b1, `FLDPS_STAT_IDX, 32'hffff, r);
    bus(1'b0, `FLDPS_STAT_IDX, 32'h0, r);
    chk("stat_write", 32'h0, r);
    bus(1'b0, 10'h3ff, 32'h0, r);
    chk("unmapped", 32'h0, r);
    bus(1'b1, `FLDPS_CTRL_IDX, 32'h0004, r);
    wait_pos(960);
    base = drops;
    fldps_link_partner_i.burst(2, 19);
    wait_pos(30);
    fldps_link_partner_i.burst(2, 19);
    repeat (6) @(posedge hclk);
    chk("split_window", 32'h0, drops - base);
    $display("hand tests done");
    conclude();
  end
endmodule
`default_nettype wire
